// >>> shared/plane_access_pkg.sv
// Purpose: constants for the legacy plane access datapath
// Assumes: byte-wide index/data ports, four planes of 64KB each
// Notes: port addresses are the low 10 bits of the I/O address
package plane_access_pkg;
    // ****************************************
    // Ports
    // ****************************************
    localparam logic [9:0] SEQ_INDEX_PORT = 10'h3C4;
    localparam logic [9:0] SEQ_DATA_PORT = 10'h3C5;
    localparam logic [9:0] GFX_INDEX_PORT = 10'h3CE;
    localparam logic [9:0] GFX_DATA_PORT = 10'h3CF;
    // ****************************************
    // Sequencer indexes
    // ****************************************
    localparam logic [2:0] SEQ_PLANE_WRITE_MASK = 3'h2;
    localparam logic [2:0] SEQ_FONT_MAP_SELECT = 3'h3;
    localparam logic [2:0] SEQ_MEMORY_MODE = 3'h4;
    localparam logic [2:0] SEQ_CHAR_COUNTER_RESET = 3'h7;
    // ****************************************
    // Graphics indexes
    // ****************************************
    localparam logic [4:0] GFX_PLANE_FILL_VALUE = 5'h00;
    localparam logic [4:0] GFX_PLANE_FILL_ENABLE = 5'h01;
    localparam logic [4:0] GFX_COLOR_MATCH_VALUE = 5'h02;
    localparam logic [4:0] GFX_WRITE_ROTATE_LOGIC = 5'h03;
    localparam logic [4:0] GFX_MODE_SELECT = 5'h05;
    localparam logic [4:0] GFX_COLOR_IGNORE_MASK = 5'h07;
    localparam logic [4:0] GFX_PIXEL_BIT_MASK = 5'h08;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int MEM_MODE_INTERLEAVE_BIT = 3;
    localparam int MEM_MODE_PAIRED_BIT = 2;
    localparam int MEM_MODE_EXT_MEM_BIT = 1;
    localparam logic [7:0] MEM_MODE_RW_MASK = 8'h0E;
    localparam logic [7:0] FONT_MAP_RW_MASK = 8'h3F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int FONT_MAP_SHIFT = 13;
    localparam int SMALL_WINDOW_BITS = 16;
    localparam int FULL_WINDOW_BITS = 18;
    localparam logic [1:0] FUNC_PASS = 2'h0;
    localparam logic [1:0] FUNC_AND = 2'h1;
    localparam logic [1:0] FUNC_OR = 2'h2;
    localparam logic [1:0] FUNC_XOR = 2'h3;
    localparam logic [1:0] WRITE_MODE_0 = 2'h0;
    localparam logic [1:0] WRITE_MODE_3 = 2'h3;
endpackage : plane_access_pkg

// >>> rtl/plane_store.sv
// Purpose: four byte-wide planes of frame memory
// Assumes: one access per cycle, registered read data
// Notes: writes per plane carry a per-bit mask
`timescale 1ns/1ps
module plane_store #(
    parameter int ADDR_BITS = 16
) (
    input wire logic clk_i,
    input wire logic [ADDR_BITS-1:0] addr_i,
    input wire logic [3:0] we_i,
    input wire logic [7:0] bit_mask_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [0:(1<<ADDR_BITS)-1];

    // Plane address never wider than the aperture
    if (ADDR_BITS < 1 || ADDR_BITS > 18)
    begin : addr_bits_check
        $error("plane_store ADDR_BITS out of range");
    end

    always_ff @(posedge clk_i)
    begin
        for (int p = 0; p < 4; p++)
        begin
            if (we_i[p])
            begin
                for (int b = 0; b < 8; b++)
                begin
                    if (bit_mask_i[b])
                    begin
                        mem[addr_i][p*8+b] <= wdata_i[p*8+b];
                    end
                end
            end
        end
        rdata_o <= mem[addr_i];
    end
endmodule : plane_store

// >>> rtl/plane_write_alu.sv
// Purpose: CPU write datapath, rotate then fill then latch function
// Assumes: pure combinational
// Notes: pixel mask applied by the caller through the store
`timescale 1ns/1ps
module plane_write_alu (
    input wire logic [7:0] cpu_data_i,
    input wire logic [2:0] rotate_i,
    input wire logic [1:0] func_i,
    input wire logic [1:0] write_mode_i,
    input wire logic [3:0] fill_value_i,
    input wire logic [3:0] fill_enable_i,
    input wire logic [31:0] latch_i,
    output logic [31:0] data_o,
    output logic [7:0] rotated_o
);
    logic [15:0] doubled;
    logic [31:0] filled;
    logic [31:0] combined;

    assign doubled = {cpu_data_i, cpu_data_i} >> rotate_i;
    assign rotated_o = doubled[7:0];

    // Rotate first, substitute, then combine with latch
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            if (write_mode_i == plane_access_pkg::WRITE_MODE_3)
                filled[p*8 +: 8] = {8{fill_value_i[p]}};
            else if (write_mode_i == plane_access_pkg::WRITE_MODE_0 && fill_enable_i[p])
                filled[p*8 +: 8] = {8{fill_value_i[p]}};
            else
                filled[p*8 +: 8] = rotated_o;
        end
    end

    always_comb
    begin
        unique case (func_i)
            plane_access_pkg::FUNC_PASS: combined = filled;
            plane_access_pkg::FUNC_AND: combined = filled & latch_i;
            plane_access_pkg::FUNC_OR: combined = filled | latch_i;
            plane_access_pkg::FUNC_XOR: combined = filled ^ latch_i;
        endcase
    end
    assign data_o = combined;
endmodule : plane_write_alu

// >>> rtl/plane_access.sv
// Purpose: index/data registers and CPU access to four-plane memory
// Assumes: one byte access per request, registered answers
// Notes: mode and bit-mask registers held here as well
//
// Behaviour
// - Secondary font from bits 3:2 and 5
// - Primary font from bits 1:0 and 4
// - Attribute bit 3 picks font when fonts differ
// - Without extended memory only maps 0, 4
// - Extended memory off limits access to 64KB
// - Interleave uses address bits 1:0 as plane
// - Paired mode: address bit 0 picks plane pair
// - Sequential mode uses plane write mask planes
// - Plane write mask gates each plane write
// - Counter reset register write has no effect
// - Graphics index selects data port register
// - Write mode 0 fills enabled planes
// - Fill enable only matters in write mode 0
// - Write mode 3 masks by rotated data
// - Read mode 1 returns colour compare result
// - Logic function combines data with latch
// - Rotate write data right by count
`timescale 1ns/1ps
module plane_access (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [9:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_ack_o,
    input wire logic mem_wr_i,
    input wire logic mem_rd_i,
    input wire logic [17:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o,
    output logic mem_ack_o,
    input wire logic attr_bit3_i,
    output logic [15:0] font_base_o,
    output logic intensity_o
);
    // ****************************************
    // Registers
    // ****************************************
    logic [2:0] seq_index_q;
    logic [4:0] gfx_index_q;
    logic [3:0] plane_write_mask_q;
    logic [7:0] font_map_select_q;
    logic [7:0] memory_mode_q;
    logic [7:0] char_counter_reset_q;
    logic [3:0] fill_value_q;
    logic [3:0] fill_enable_q;
    logic [3:0] color_match_q;
    logic [4:0] rotate_logic_q;
    logic [7:0] mode_select_q;
    logic [3:0] color_ignore_q;
    logic [7:0] pixel_mask_q;
    logic [31:0] latch_q;
    logic [7:0] io_rdata_q;
    logic io_ack_q;
    logic mem_ack_q;
    logic rd_pend_q;
    logic [1:0] rd_plane_q;
    logic [15:0] font_base_q;
    logic intensity_q;

    // ****************************************
    // Decode
    // ****************************************
    wire seq_data_sel = io_addr_i == plane_access_pkg::SEQ_DATA_PORT;
    wire gfx_data_sel = io_addr_i == plane_access_pkg::GFX_DATA_PORT;
    wire seq_wr = io_wr_i && seq_data_sel;
    wire gfx_wr = io_wr_i && gfx_data_sel;
    wire ext_mem = memory_mode_q[plane_access_pkg::MEM_MODE_EXT_MEM_BIT];
    wire interleave = memory_mode_q[plane_access_pkg::MEM_MODE_INTERLEAVE_BIT];
    wire paired_off = memory_mode_q[plane_access_pkg::MEM_MODE_PAIRED_BIT];
    wire [1:0] write_mode = mode_select_q[1:0];
    wire read_mode1 = mode_select_q[3];

    function automatic logic [2:0] map_number(input logic [1:0] lo, input logic hi);
        map_number = {hi, lo};
    endfunction : map_number

    // Map n lives at 8K * (low bits * 2 + high bit) in plane 2
    function automatic logic [15:0] map_base(input logic [1:0] lo, input logic hi);
        map_base = 16'({lo, hi}) << plane_access_pkg::FONT_MAP_SHIFT;
    endfunction : map_base

    wire [1:0] sec_lo = font_map_select_q[3:2];
    wire [1:0] pri_lo = font_map_select_q[1:0];
    // Without extended memory only maps 0 and 4 reachable
    wire [1:0] sec_lo_eff = ext_mem ? sec_lo : 2'h0;
    wire [1:0] pri_lo_eff = ext_mem ? pri_lo : 2'h0;
    wire fonts_differ = map_number(pri_lo_eff, font_map_select_q[4])
        != map_number(sec_lo_eff, font_map_select_q[5]);
    wire [15:0] font_base_d = (fonts_differ && attr_bit3_i)
        ? map_base(sec_lo_eff, font_map_select_q[5])
        : map_base(pri_lo_eff, font_map_select_q[4]);
    wire intensity_d = !fonts_differ && attr_bit3_i;

    // ****************************************
    // Address mapping
    // ****************************************
    wire mem_req = mem_wr_i || mem_rd_i;
    wire in_window = ext_mem || (mem_addr_i[17:16] == 2'h0);
    logic [15:0] plane_addr;
    logic [3:0] plane_sel;
    always_comb
    begin
        if (interleave)
        begin
            plane_addr = mem_addr_i[17:2];
            plane_sel = 4'h1 << mem_addr_i[1:0];
        end
        else if (!paired_off)
        begin
            plane_addr = mem_addr_i[16:1];
            plane_sel = mem_addr_i[0] ? 4'hA : 4'h5;
        end
        else
        begin
            plane_addr = mem_addr_i[15:0];
            plane_sel = 4'hF;
        end
    end
    wire [3:0] plane_we = (mem_wr_i && in_window)
        ? (plane_sel & plane_write_mask_q) : 4'h0;

    // ****************************************
    // Datapath
    // ****************************************
    logic [31:0] alu_data;
    logic [7:0] rotated;
    logic [31:0] store_rdata;
    plane_write_alu u_alu (
        .cpu_data_i(mem_wdata_i),
        .rotate_i(rotate_logic_q[2:0]),
        .func_i(rotate_logic_q[4:3]),
        .write_mode_i(write_mode),
        .fill_value_i(fill_value_q),
        .fill_enable_i(fill_enable_q),
        .latch_i(latch_q),
        .data_o(alu_data),
        .rotated_o(rotated)
    );
    wire [7:0] bit_mask = (write_mode == plane_access_pkg::WRITE_MODE_3)
        ? (rotated & pixel_mask_q) : pixel_mask_q;
    plane_store #(
        .ADDR_BITS(plane_access_pkg::SMALL_WINDOW_BITS)
    ) u_store (
        .clk_i(clk_i),
        .addr_i(plane_addr),
        .we_i(plane_we),
        .bit_mask_i(bit_mask),
        .wdata_i(alu_data),
        .rdata_o(store_rdata)
    );

    function automatic logic [7:0] compare(input logic [31:0] d, input logic [3:0] col,
                                           input logic [3:0] care);
        compare = 8'hFF;
        for (int p = 0; p < 4; p++)
        begin
            if (care[p])
            begin
                compare = compare & ~(d[p*8 +: 8] ^ {8{col[p]}});
            end
        end
    endfunction : compare

    wire [7:0] plane_byte = store_rdata[rd_plane_q*8 +: 8];
    wire [7:0] read_d = read_mode1
        ? compare(store_rdata, color_match_q, color_ignore_q) : plane_byte;

    // ****************************************
    // Register reads
    // ****************************************
    logic [7:0] reg_rdata;
    always_comb
    begin
        reg_rdata = 8'h00;
        if (io_addr_i == plane_access_pkg::SEQ_INDEX_PORT)
            reg_rdata = {5'h00, seq_index_q};
        else if (io_addr_i == plane_access_pkg::GFX_INDEX_PORT)
            reg_rdata = {3'h0, gfx_index_q};
        else if (seq_data_sel)
        begin
            unique case (seq_index_q)
                plane_access_pkg::SEQ_PLANE_WRITE_MASK: reg_rdata = {4'h0, plane_write_mask_q};
                plane_access_pkg::SEQ_FONT_MAP_SELECT: reg_rdata = font_map_select_q;
                plane_access_pkg::SEQ_MEMORY_MODE: reg_rdata = memory_mode_q;
                plane_access_pkg::SEQ_CHAR_COUNTER_RESET: reg_rdata = char_counter_reset_q;
                default: reg_rdata = 8'h00;
            endcase
        end
        else if (gfx_data_sel)
        begin
            unique case (gfx_index_q)
                plane_access_pkg::GFX_PLANE_FILL_VALUE: reg_rdata = {4'h0, fill_value_q};
                plane_access_pkg::GFX_PLANE_FILL_ENABLE: reg_rdata = {4'h0, fill_enable_q};
                plane_access_pkg::GFX_COLOR_MATCH_VALUE: reg_rdata = {4'h0, color_match_q};
                plane_access_pkg::GFX_WRITE_ROTATE_LOGIC: reg_rdata = {3'h0, rotate_logic_q};
                plane_access_pkg::GFX_MODE_SELECT: reg_rdata = mode_select_q;
                plane_access_pkg::GFX_COLOR_IGNORE_MASK: reg_rdata = {4'h0, color_ignore_q};
                plane_access_pkg::GFX_PIXEL_BIT_MASK: reg_rdata = pixel_mask_q;
                default: reg_rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            seq_index_q <= 3'h0;
            plane_write_mask_q <= 4'h0;
            font_map_select_q <= plane_access_pkg::REG_RESET;
            memory_mode_q <= plane_access_pkg::REG_RESET;
            char_counter_reset_q <= plane_access_pkg::REG_RESET;
        end
        else
        begin
            if (io_wr_i && io_addr_i == plane_access_pkg::SEQ_INDEX_PORT)
                seq_index_q <= io_wdata_i[2:0];
            if (seq_wr && seq_index_q == plane_access_pkg::SEQ_PLANE_WRITE_MASK)
                plane_write_mask_q <= io_wdata_i[3:0];
            if (seq_wr && seq_index_q == plane_access_pkg::SEQ_FONT_MAP_SELECT)
                font_map_select_q <= io_wdata_i & plane_access_pkg::FONT_MAP_RW_MASK;
            if (seq_wr && seq_index_q == plane_access_pkg::SEQ_MEMORY_MODE)
                memory_mode_q <= io_wdata_i & plane_access_pkg::MEM_MODE_RW_MASK;
            // Plain storage: no counter hold, no release sequence
            if (seq_wr && seq_index_q == plane_access_pkg::SEQ_CHAR_COUNTER_RESET)
                char_counter_reset_q <= io_wdata_i;
        end
    end

    // ****************************************
    // Graphics registers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            gfx_index_q <= 5'h00;
            fill_value_q <= 4'h0;
            fill_enable_q <= 4'h0;
            color_match_q <= 4'h0;
            rotate_logic_q <= 5'h00;
            mode_select_q <= 8'h00;
            color_ignore_q <= 4'h0;
            pixel_mask_q <= 8'hFF;
        end
        else
        begin
            if (io_wr_i && io_addr_i == plane_access_pkg::GFX_INDEX_PORT)
                gfx_index_q <= io_wdata_i[4:0];
            if (gfx_wr && gfx_index_q == plane_access_pkg::GFX_PLANE_FILL_VALUE)
                fill_value_q <= io_wdata_i[3:0];
            if (gfx_wr && gfx_index_q == plane_access_pkg::GFX_PLANE_FILL_ENABLE)
                fill_enable_q <= io_wdata_i[3:0];
            if (gfx_wr && gfx_index_q == plane_access_pkg::GFX_COLOR_MATCH_VALUE)
                color_match_q <= io_wdata_i[3:0];
            if (gfx_wr && gfx_index_q == plane_access_pkg::GFX_WRITE_ROTATE_LOGIC)
                rotate_logic_q <= io_wdata_i[4:0];
            if (gfx_wr && gfx_index_q == plane_access_pkg::GFX_MODE_SELECT)
                mode_select_q <= {1'b0, io_wdata_i[6:0]};
            if (gfx_wr && gfx_index_q == plane_access_pkg::GFX_COLOR_IGNORE_MASK)
                color_ignore_q <= io_wdata_i[3:0];
            if (gfx_wr && gfx_index_q == plane_access_pkg::GFX_PIXEL_BIT_MASK)
                pixel_mask_q <= io_wdata_i;
        end
    end

    // ****************************************
    // Answers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            io_rdata_q <= 8'h00;
            io_ack_q <= 1'b0;
            mem_ack_q <= 1'b0;
            rd_pend_q <= 1'b0;
            rd_plane_q <= 2'h0;
            latch_q <= 32'h0000_0000;
            font_base_q <= 16'h0000;
            intensity_q <= 1'b0;
        end
        else
        begin
            io_ack_q <= io_wr_i || io_rd_i;
            if (io_rd_i)
                io_rdata_q <= reg_rdata;
            rd_pend_q <= mem_rd_i && in_window;
            rd_plane_q <= interleave ? mem_addr_i[1:0] : {1'b0, mem_addr_i[0] & !paired_off};
            // Latch refreshed by every in-window read so logic ops see it
            if (rd_pend_q)
                latch_q <= store_rdata;
            mem_ack_q <= mem_req && !rd_pend_q ? !mem_rd_i || !in_window : rd_pend_q;
            font_base_q <= font_base_d;
            intensity_q <= intensity_d;
        end
    end

    logic [7:0] mem_rdata_q;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            mem_rdata_q <= 8'h00;
        else if (rd_pend_q)
            mem_rdata_q <= read_d;
        else if (mem_rd_i && !in_window)
            mem_rdata_q <= 8'hFF;
    end

    assign io_rdata_o = io_rdata_q;
    assign io_ack_o = io_ack_q;
    assign mem_rdata_o = mem_rdata_q;
    assign mem_ack_o = mem_ack_q;
    assign font_base_o = font_base_q;
    assign intensity_o = intensity_q;

    // ****************************************
    // Checks
    // ****************************************
    window_limit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ext_mem && mem_addr_i[17:16] != 2'h0 |-> plane_we == 4'h0)
        else $error("write outside 64KB window");
    mask_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (plane_we & ~plane_write_mask_q) == 4'h0)
        else $error("masked plane written");
    interleave_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        interleave |-> plane_sel == (4'h1 << mem_addr_i[1:0]))
        else $error("interleave plane select wrong");
    pair_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !interleave && !paired_off && mem_addr_i[0] |-> plane_sel == 4'hA)
        else $error("odd address not planes 1 and 3");
    font_limit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ext_mem |=> font_base_o[15:14] == 2'h0)
        else $error("font map beyond 0 and 4");
    intensity_rule_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fonts_differ |=> !intensity_o)
        else $error("intensity set while fonts differ");
    read_answer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mem_rd_i && in_window && !rd_pend_q |=> ##1 mem_ack_o)
        else $error("read answer late");
    index_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        io_wr_i && io_addr_i == plane_access_pkg::GFX_INDEX_PORT
        |=> gfx_index_q == $past(io_wdata_i[4:0]))
        else $error("graphics index not stored");
endmodule : plane_access

// >>> dv/host_model.sv
// Purpose: host side issuing port and aperture accesses
// Assumes: strobes are one-cycle pulses launched at the falling edge
// Notes: a missing ack is counted in lost_acks for the bench
`timescale 1ns/1ps
module host_model (
    input wire logic clk_i,
    input wire logic io_ack_i,
    input wire logic mem_ack_i,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [9:0] io_addr_o,
    output logic [7:0] io_wdata_o,
    output logic mem_wr_o,
    output logic mem_rd_o,
    output logic [17:0] mem_addr_o,
    output logic [7:0] mem_wdata_o
);
    int lost_acks = 0;
    initial
    begin
        {io_wr_o, io_rd_o, mem_wr_o, mem_rd_o} = 4'h0;
        io_addr_o = 10'h000;
        io_wdata_o = 8'h00;
        mem_addr_o = 18'h00000;
        mem_wdata_o = 8'h00;
    end
    // ****************************************
    // Request and bounded wait for ack
    // ****************************************
    task automatic finish_req(input logic use_mem);
        int n;
        n = 0;
        @(negedge clk_i);
        {io_wr_o, io_rd_o, mem_wr_o, mem_rd_o} = 4'h0;
        while ((use_mem ? mem_ack_i : io_ack_i) !== 1'b1 && n < 4)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n == 4)
        begin
            lost_acks++;
        end
        // Released data must not look like the last value
        io_wdata_o = ~io_wdata_o;
        mem_wdata_o = ~mem_wdata_o;
    endtask : finish_req
    task automatic io(input logic wr, input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_i);
        io_addr_o = a;
        io_wdata_o = d;
        io_wr_o = wr;
        io_rd_o = !wr;
        finish_req(1'b0);
    endtask : io
    task automatic mem(input logic wr, input logic [17:0] a, input logic [7:0] d);
        @(negedge clk_i);
        mem_addr_o = a;
        mem_wdata_o = d;
        mem_wr_o = wr;
        mem_rd_o = !wr;
        finish_req(1'b1);
    endtask : mem
endmodule : host_model

// >>> dv/testbench.sv
// Purpose: self-checking bench for the plane access block
// Assumes: host_model issues every request
// Notes: inputs change at the falling edge only
`timescale 1ns/1ps
module testbench;
    logic clk_i, rst_n_i, attr_bit3_i, io_wr, io_rd, io_ack, mem_wr, mem_rd, mem_ack, inten;
    logic [9:0] io_addr;
    logic [17:0] mem_addr;
    logic [7:0] io_wdata, io_rdata, mem_wdata, mem_rdata;
    logic [15:0] font_base;
    int n_mismatch = 0;
    int total_checks = 0;
    plane_access i_plane_access (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_wr_i(io_wr),
        .io_rd_i(io_rd), .io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
        .io_ack_o(io_ack), .mem_wr_i(mem_wr), .mem_rd_i(mem_rd), .mem_addr_i(mem_addr),
        .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack),
        .attr_bit3_i(attr_bit3_i), .font_base_o(font_base), .intensity_o(inten));
    host_model i_host_model (.clk_i(clk_i), .io_ack_i(io_ack), .mem_ack_i(mem_ack),
        .io_wr_o(io_wr), .io_rd_o(io_rd), .io_addr_o(io_addr), .io_wdata_o(io_wdata),
        .mem_wr_o(mem_wr), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata));
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic ra(input logic g, input logic wr, input logic [4:0] i, input logic [7:0] v);
        logic [9:0] ip;
        ip = g ? plane_access_pkg::GFX_INDEX_PORT : plane_access_pkg::SEQ_INDEX_PORT;
        i_host_model.io(1'b1, ip, {3'h0, i});
        i_host_model.io(wr, ip + 10'h001, v);
        if (!wr)
        begin
            chk({8'h00, io_rdata}, {8'h00, v});
        end
    endtask : ra
    task automatic ma(input logic wr, input logic [17:0] a, input logic [7:0] d);
        i_host_model.mem(wr, a, d);
        if (!wr)
        begin
            chk({8'h00, mem_rdata}, {8'h00, d});
        end
    endtask : ma
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        ra(0, 0, 5'h04, 8'h00);
        ra(0, 1, 5'h04, 8'hFF);
        ra(0, 0, 5'h04, 8'h0E);
        ra(0, 1, 5'h03, 8'hFF);
        ra(0, 0, 5'h03, 8'h3F);
        ra(0, 1, 5'h07, 8'h5A);
        ra(0, 0, 5'h07, 8'h5A);
        ra(1, 1, 5'h00, 8'h05);
        ra(1, 1, 5'h02, 8'h0A);
        ra(1, 0, 5'h00, 8'h05);
        ra(1, 0, 5'h02, 8'h0A);
        ra(1, 0, 5'h1F, 8'h00);
    endtask : t_regs
    task automatic t_font();
        logic [15:0] b0;
        for (int e = 0; e < 2; e++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                ra(0, 1, 5'h04, e ? 8'h02 : 8'h00);
                ra(0, 1, 5'h03, {2'h0, k[0], k[0], k[2:1], k[2:1]});
                for (int a = 0; a < 2; a++)
                begin
                    attr_bit3_i = a[0];
                    repeat (3) @(negedge clk_i);
                    chk(font_base, e ? {k[2:0], 13'h0} : {2'h0, k[0], 13'h0});
                    chk({15'h0, inten}, {15'h0, a[0]});
                end
            end
        end
        ra(0, 1, 5'h04, 8'h02);
        ra(0, 1, 5'h03, 8'h29);
        attr_bit3_i = 1'b0;
        repeat (3) @(negedge clk_i);
        b0 = font_base;
        attr_bit3_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk(b0 ^ font_base, 16'hE000);
        chk(b0, 16'h4000);
        chk({15'h0, inten}, 16'h0000);
    endtask : t_font
    task automatic t_mem();
        logic [7:0] v[4] = '{8'hF0, 8'hCC, 8'hAA, 8'h00};
        ra(0, 1, 5'h02, 8'h0F);
        ra(0, 1, 5'h04, 8'h0A);
        for (int i = 0; i < 4; i++) ma(1, 18'(i), v[3 - i]);
        for (int i = 0; i < 4; i++) ma(0, 18'(i), v[3 - i]);
        ra(0, 1, 5'h04, 8'h02);
        ma(1, 18'h00100, 8'h5A);
        ma(1, 18'h00101, 8'hA5);
        ma(0, 18'h00100, 8'h5A);
        ma(0, 18'h00101, 8'hA5);
        ra(0, 1, 5'h04, 8'h06);
        for (int p = 0; p < 4; p++)
        begin
            ra(0, 1, 5'h02, 8'h01 << p);
            ma(1, 18'h00300, v[p]);
        end
        ma(0, 18'h00300, 8'hF0);
        ra(1, 1, 5'h05, 8'h08);
        ra(1, 1, 5'h02, 8'h01);
        ra(1, 1, 5'h07, 8'h0F);
        ma(0, 18'h00300, 8'h10);
        ra(1, 1, 5'h07, 8'h03);
        ma(0, 18'h00300, 8'h30);
        ra(1, 1, 5'h05, 8'h00);
        ra(0, 1, 5'h04, 8'h04);
        ra(0, 1, 5'h02, 8'h0F);
        ma(1, 18'h10300, 8'h77);
        ma(0, 18'h10300, 8'hFF);
        ma(0, 18'h00300, 8'hF0);
    endtask : t_mem
    task automatic t_alu();
        logic [15:0] t;
        ra(0, 1, 5'h04, 8'h06);
        ra(0, 1, 5'h02, 8'h01);
        for (int r = 0; r < 8; r++)
        begin
            ra(1, 1, 5'h03, 8'(r));
            ma(1, 18'h00400, 8'h03);
            t = 16'h0303 >> r;
            ma(0, 18'h00400, t[7:0]);
        end
        for (int f = 1; f < 4; f++)
        begin
            ra(1, 1, 5'h03, 8'h00);
            ma(1, 18'h00400, 8'hF0);
            ma(0, 18'h00400, 8'hF0);
            ra(1, 1, 5'h03, {3'h0, 2'(f), 3'h0});
            ma(1, 18'h00400, 8'h3C);
            ma(0, 18'h00400, f == 1 ? 8'h30 : f == 2 ? 8'hFC : 8'hCC);
        end
        ra(1, 1, 5'h03, 8'h01);
        ra(1, 1, 5'h01, 8'h01);
        ra(1, 1, 5'h00, 8'h01);
        ma(1, 18'h00400, 8'h00);
        ma(0, 18'h00400, 8'hFF);
        ra(1, 1, 5'h00, 8'h00);
        ma(1, 18'h00400, 8'h55);
        ma(0, 18'h00400, 8'h00);
        ra(1, 1, 5'h05, 8'h03);
        ra(1, 1, 5'h01, 8'h00);
        ra(1, 1, 5'h00, 8'h01);
        ra(1, 1, 5'h03, 8'h04);
        ma(1, 18'h00400, 8'hF0);
        ma(0, 18'h00400, 8'h0F);
    endtask : t_alu
    task automatic end_of_test();
        n_mismatch = n_mismatch + i_host_model.lost_acks;
        if (n_mismatch == 0 && total_checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (30000) @(posedge clk_i);
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        rst_n_i = 1'b0;
        attr_bit3_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_regs();
        t_font();
        t_mem();
        t_alu();
        end_of_test();
    end
endmodule : testbench
